// ===== rtl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    // register indices on the plain port
    localparam logic [2:0] ADDR_FLAG       = 3'h0;
    localparam logic [2:0] ADDR_ENABLE     = 3'h1;
    localparam logic [2:0] ADDR_SH_WORKING = 3'h2;
    localparam logic [2:0] ADDR_SH_STATUS  = 3'h3;
    localparam logic [2:0] ADDR_SH_POINTER = 3'h4;
    localparam logic [2:0] ADDR_SH_BANK    = 3'h5;
    localparam logic [2:0] ADDR_WAKE_CFG   = 3'h6;

    // flag register fields
    localparam int ADC_DONE_BIT   = 7;
    localparam int CMP_CHANGE_BIT = 6;
    localparam int TIMER_OVF_BIT  = 5;
    localparam int PIN_CHANGE_BIT = 4;
    localparam int GIE_BIT        = 0;

    // enable register fields
    localparam int ADC_IE_BIT   = 7;
    localparam int CMP_IE_BIT   = 6;
    localparam int TIMER_IE_BIT = 5;
    localparam int PIN_IE_BIT   = 4;
    localparam int WUR_BIT      = 0;

    // wake disable config fields (own register)
    localparam int CMP1_WD_BIT = 0;
    localparam int CMP2_WD_BIT = 1;
    localparam int PIN_WD_BIT  = 2;

    localparam logic [7:0] FLAG_RESET     = 8'h00;
    localparam logic [7:0] ENABLE_RESET   = 8'h00;
    localparam logic [7:0] WAKE_CFG_RESET = 8'h00;
    localparam logic [7:0] FLAG_MASK      = 8'hf1;
    localparam logic [7:0] ENABLE_MASK    = 8'hf1;
    localparam logic [7:0] WAKE_CFG_MASK  = 8'h07;
    localparam logic [10:0] IRQ_VECTOR    = 11'h004;

    typedef enum logic [1:0] {
        ST_RUN    = 2'b00,
        ST_SLEEP  = 2'b01,
        ST_AFTER  = 2'b11
    } core_state_t;

endpackage

// ===== rtl/ctx_bank.sv
`timescale 1ns/1ps
// one main/shadow pair; the shadow half is never reset (contents undefined at power-on)
module ctx_bank (
    // clock
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    // control
    input  wire logic       in_isr,
    input  wire logic       cpu_we,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       alias_we,
    input  wire logic [7:0] alias_wdata,
    // view
    output logic      [7:0] active_val,
    output logic      [7:0] alias_val
);
    logic [7:0] main_q;
    logic [7:0] main_d;
    logic [7:0] shad_q;
    logic [7:0] shad_d;

    always_comb begin
        main_d = main_q;
        shad_d = shad_q;
        if (alias_we) begin
            if (in_isr) main_d = alias_wdata;
            else shad_d = alias_wdata;
        end
        if (cpu_we) begin
            if (in_isr) shad_d = cpu_wdata;
            else main_d = cpu_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) main_q <= 8'h00;
        else main_q <= main_d;
        shad_q <= shad_d;
    end

    assign active_val = in_isr ? shad_q : main_q;
    assign alias_val  = in_isr ? main_q : shad_q;
endmodule

// ===== rtl/irq_ctrl_context_switch.sv
`timescale 1ns/1ps
// Overview of operation
// - reset clears the global enable.
// - a source interrupts only with global and own enable set.
// - source enables live in enable register, pending events and global enable as flags.
// - adc and timer flags set regardless of any enable.
// - comparator change sets flag only while that comparator's disable is clear.
// - pin change sets flag only while pin wake disable is clear.
// - taking an irq: flush, clear enable, push pc, swap context, vector 0004h.
// - with global enable clear, flags record but no vectoring.
// - pending enabled flags are serviced once global enable returns.
// - routine uses shadow working, status, pointer, bank registers.
// - shadow aliases read the other context.
// - return pops address, restores main set, sets global enable.
// - shadow context is not initialised by reset.
// - wake vectors if global enable set, else continues inline.
// - the instruction after sleep runs before vectoring.
// - adc flag bit 7 sets on completion, stays until cleared.
// - with wake reset selected, a wake resets the device.
// - enable bits: adc 7, comparator 6, timer 5, pin 4, wake reset 0.
module irq_ctrl_context_switch
    import irq_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // peripheral events
    input  wire logic        adc_done,
    input  wire logic        timer_ovf,
    input  wire logic        cmp1_out,
    input  wire logic        cmp2_out,
    input  wire logic        pin_change,
    // core pipeline
    input  wire logic        sleep_exec,
    input  wire logic        return_from_irq_instr_exec,
    input  wire logic        instr_retire,
    input  wire logic        ctx_we_w,
    input  wire logic        ctx_we_status,
    input  wire logic        ctx_we_ptr,
    input  wire logic        ctx_we_bank,
    input  wire logic [7:0]  ctx_wdata,
    // to core
    output logic             flush,
    output logic             push_pc,
    output logic             pop_pc,
    output logic             load_vector,
    output logic      [10:0] vector_addr,
    output logic             in_isr,
    output logic             core_asleep,
    output logic             wake_reset_req,
    output logic      [31:0] ctx_active
);
    import irq_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // event inputs: three-stage synchronisers, change when stages 2 and 3 agree
    logic [2:0] cmp1_s_q;
    logic [2:0] cmp2_s_q;
    logic [2:0] pin_s_q;
    logic [2:0] adc_s_q;
    logic [2:0] tmr_s_q;
    logic       cmp1_st_q;
    logic       cmp2_st_q;
    logic       pin_st_q;
    logic       adc_st_q;
    logic       tmr_st_q;
    logic       cmp1_ev;
    logic       cmp2_ev;
    logic       pin_ev;
    logic       adc_ev;
    logic       tmr_ev;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cmp1_s_q <= 3'h0;
            cmp2_s_q <= 3'h0;
            pin_s_q  <= 3'h0;
            adc_s_q  <= 3'h0;
            tmr_s_q  <= 3'h0;
        end else begin
            cmp1_s_q <= {cmp1_s_q[1:0], cmp1_out};
            cmp2_s_q <= {cmp2_s_q[1:0], cmp2_out};
            pin_s_q  <= {pin_s_q[1:0], pin_change};
            adc_s_q  <= {adc_s_q[1:0], adc_done};
            tmr_s_q  <= {tmr_s_q[1:0], timer_ovf};
        end
    end

    // stable level tracks stage 2/3 agreement; event is a change of it
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cmp1_st_q <= 1'b0;
            cmp2_st_q <= 1'b0;
            pin_st_q  <= 1'b0;
            adc_st_q  <= 1'b0;
            tmr_st_q  <= 1'b0;
        end else begin
            if (cmp1_s_q[1] == cmp1_s_q[2]) cmp1_st_q <= cmp1_s_q[2];
            if (cmp2_s_q[1] == cmp2_s_q[2]) cmp2_st_q <= cmp2_s_q[2];
            if (pin_s_q[1] == pin_s_q[2]) pin_st_q <= pin_s_q[2];
            if (adc_s_q[1] == adc_s_q[2]) adc_st_q <= adc_s_q[2];
            if (tmr_s_q[1] == tmr_s_q[2]) tmr_st_q <= tmr_s_q[2];
        end
    end

    // comparator: any edge; pin, adc, timer: rising edge of event level
    assign cmp1_ev = (cmp1_s_q[1] == cmp1_s_q[2]) && (cmp1_s_q[2] != cmp1_st_q);
    assign cmp2_ev = (cmp2_s_q[1] == cmp2_s_q[2]) && (cmp2_s_q[2] != cmp2_st_q);
    assign pin_ev  = (pin_s_q[1] == pin_s_q[2]) && pin_s_q[2] && !pin_st_q;
    assign adc_ev  = (adc_s_q[1] == adc_s_q[2]) && adc_s_q[2] && !adc_st_q;
    assign tmr_ev  = (tmr_s_q[1] == tmr_s_q[2]) && tmr_s_q[2] && !tmr_st_q;

    ////////////////////////////////////////////////////////////////////////
    // flag, enable and wake config registers
    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic [7:0] enable_q;
    logic [7:0] enable_d;
    logic [7:0] wake_cfg_q;
    logic [7:0] wake_cfg_d;
    logic       take_irq;
    logic       irq_pending;
    logic [3:0] src_hit;

    assign src_hit[3] = flag_q[ADC_DONE_BIT]   & enable_q[ADC_IE_BIT];
    assign src_hit[2] = flag_q[CMP_CHANGE_BIT] & enable_q[CMP_IE_BIT];
    assign src_hit[1] = flag_q[TIMER_OVF_BIT]  & enable_q[TIMER_IE_BIT];
    assign src_hit[0] = flag_q[PIN_CHANGE_BIT] & enable_q[PIN_IE_BIT];
    assign irq_pending = |src_hit;

    always_comb begin
        flag_d     = flag_q;
        enable_d   = enable_q;
        wake_cfg_d = wake_cfg_q;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_FLAG:     flag_d     = reg_wdata & FLAG_MASK;
                ADDR_ENABLE:   enable_d   = reg_wdata & ENABLE_MASK;
                ADDR_WAKE_CFG: wake_cfg_d = reg_wdata & WAKE_CFG_MASK;
                default: ;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (adc_ev) flag_d[ADC_DONE_BIT] = 1'b1;
        if (tmr_ev) flag_d[TIMER_OVF_BIT] = 1'b1;
        if ((cmp1_ev && !wake_cfg_q[CMP1_WD_BIT]) ||
            (cmp2_ev && !wake_cfg_q[CMP2_WD_BIT])) begin
            flag_d[CMP_CHANGE_BIT] = 1'b1;
        end
        if (pin_ev && !wake_cfg_q[PIN_WD_BIT]) begin
            flag_d[PIN_CHANGE_BIT] = 1'b1;
        end
        if (take_irq) flag_d[GIE_BIT] = 1'b0;
        if (return_from_irq_instr_exec && in_isr) flag_d[GIE_BIT] = 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            flag_q     <= FLAG_RESET;
            enable_q   <= ENABLE_RESET;
            wake_cfg_q <= WAKE_CFG_RESET;
        end else begin
            flag_q     <= flag_d;
            enable_q   <= enable_d;
            wake_cfg_q <= wake_cfg_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // core sequencing: run, sleep, one instruction after wake
    core_state_t st_q;
    core_state_t st_d;
    logic        in_isr_d;
    logic        wake;
    logic        wake_rst_d;

    // a wake-reset request holds while asleep until the reset generator acts
    assign wake = (st_q == ST_SLEEP) && irq_pending;
    // vector only outside sleep and its trailing instruction; gie gates it
    assign take_irq = flag_q[GIE_BIT] && irq_pending && !in_isr && !return_from_irq_instr_exec &&
                      ((st_q == ST_RUN && !sleep_exec) ||
                       (st_q == ST_AFTER && instr_retire));

    always_comb begin
        st_d       = st_q;
        in_isr_d   = in_isr;
        wake_rst_d = 1'b0;
        case (st_q)
            ST_RUN: begin
                if (sleep_exec) st_d = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (wake) begin
                    if (enable_q[WUR_BIT]) wake_rst_d = 1'b1;
                    else st_d = ST_AFTER;
                end
            end
            ST_AFTER: begin
                if (instr_retire) st_d = ST_RUN;
            end
            default: st_d = ST_RUN;
        endcase
        if (take_irq) in_isr_d = 1'b1;
        else if (return_from_irq_instr_exec) in_isr_d = 1'b0;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q           <= ST_RUN;
            in_isr         <= 1'b0;
            flush          <= 1'b0;
            push_pc        <= 1'b0;
            pop_pc         <= 1'b0;
            load_vector    <= 1'b0;
            vector_addr    <= 11'h000;
            core_asleep    <= 1'b0;
            wake_reset_req <= 1'b0;
        end else begin
            st_q           <= st_d;
            in_isr         <= in_isr_d;
            flush          <= take_irq;
            push_pc        <= take_irq;
            pop_pc         <= return_from_irq_instr_exec && in_isr;
            load_vector    <= take_irq;
            vector_addr    <= take_irq ? IRQ_VECTOR : 11'h000;
            core_asleep    <= (st_d == ST_SLEEP);
            wake_reset_req <= wake_rst_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // context banks: working, status, pointer, bank select
    logic [7:0] act_val [4];
    logic [7:0] ali_val [4];
    logic [3:0] cpu_we;
    logic [3:0] ali_we;

    assign cpu_we = {ctx_we_bank, ctx_we_ptr, ctx_we_status, ctx_we_w};

    generate
        for (genvar i = 0; i < 4; i++) begin : g_ctx
            assign ali_we[i] = reg_wr && (reg_addr == ADDR_SH_WORKING + 3'(i));
            ctx_bank u_bank (
                .ref_clk     (ref_clk),
                .rst_b       (rst_b),
                .in_isr      (in_isr),
                .cpu_we      (cpu_we[i]),
                .cpu_wdata   (ctx_wdata),
                .alias_we    (ali_we[i]),
                .alias_wdata (reg_wdata),
                .active_val  (act_val[i]),
                .alias_val   (ali_val[i])
            );
        end
    endgenerate

    // one process owns the whole word: per-slice processes would mean several
    // drivers of one variable
    logic [31:0] ctx_active_d;

    assign ctx_active_d = {act_val[3], act_val[2], act_val[1], act_val[0]};

    // registered view keeps outputs straight from flops
    always_ff @(posedge ref_clk) begin
        if (!rst_b) ctx_active <= 32'h0000_0000;
        else ctx_active <= ctx_active_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // read port: data in the cycle after the strobe only
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_FLAG:       rdata_d = flag_q;
                ADDR_ENABLE:     rdata_d = enable_q;
                ADDR_SH_WORKING: rdata_d = ali_val[0];
                ADDR_SH_STATUS:  rdata_d = ali_val[1];
                ADDR_SH_POINTER: rdata_d = ali_val[2];
                ADDR_SH_BANK:    rdata_d = ali_val[3];
                ADDR_WAKE_CFG:   rdata_d = wake_cfg_q;
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) reg_rdata <= 8'h00;
        else reg_rdata <= rdata_d;
    end
endmodule

// ===== sim/irq_ctrl_checker.sv
`timescale 1ns/1ps
module irq_ctrl_checker (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_b,
    // register port and core strobes
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        sleep_exec,
    input wire logic        return_from_irq_instr_exec,
    // to core
    input wire logic        flush,
    input wire logic        push_pc,
    input wire logic        pop_pc,
    input wire logic        load_vector,
    input wire logic [10:0] vector_addr,
    input wire logic        in_isr,
    input wire logic        core_asleep,
    input wire logic        wake_reset_req
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_take;
        flush && push_pc && load_vector && vector_addr == 11'h004;
    endsequence
    sequence s_quiet;
        !flush && !push_pc && !load_vector && vector_addr == 11'h000;
    endsequence
    property p_take;
        load_vector |-> s_take ##1 s_quiet;
    endproperty
    a_take: assert property (p_take) else $error("take pulses malformed");
    property p_no_stray;
        flush || push_pc |-> load_vector;
    endproperty
    a_no_stray: assert property (p_no_stray) else $error("stray flush or push");
    property p_isr_enter;
        load_vector |-> in_isr && !$past(in_isr);
    endproperty
    a_isr_enter: assert property (p_isr_enter) else $error("shadow set not entered");
    property p_no_nest;
        in_isr && $past(in_isr) |-> !load_vector;
    endproperty
    a_no_nest: assert property (p_no_nest) else $error("vector taken inside routine");
    property p_return;
        return_from_irq_instr_exec && in_isr |=> pop_pc && !in_isr;
    endproperty
    a_return: assert property (p_return) else $error("return did not pop and restore");
    property p_pop_cause;
        pop_pc |-> $past(return_from_irq_instr_exec) && $past(in_isr);
    endproperty
    a_pop_cause: assert property (p_pop_cause) else $error("pop without return");
    property p_sleep;
        sleep_exec |=> core_asleep;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_wake_order;
        $fell(core_asleep) |-> !load_vector;
    endproperty
    a_wake_order: assert property (p_wake_order) else $error("vector before next instr");
    property p_wake_reset;
        wake_reset_req |-> !load_vector && core_asleep;
    endproperty
    a_wake_reset: assert property (p_wake_reset) else $error("wake reset malformed");
    property p_rdata;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule

// ===== sim/core_model.sv
`timescale 1ns/1ps
// core side: retires the instruction after sleep once awake
module core_model (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // from controller
    input  wire logic core_asleep,
    // to controller
    output logic      instr_retire
);
    logic asleep_q;
    logic retire_d;
    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        retire_d = asleep_q && !core_asleep;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            asleep_q     <= 1'b0;
            instr_retire <= 1'b0;
        end else begin
            asleep_q     <= core_asleep;
            instr_retire <= retire_d;
        end
    end
endmodule

// ===== sim/tb_irq_ctrl_context_switch.sv
`timescale 1ns/1ps
module tb_irq_ctrl_context_switch;
    import irq_ctrl_pkg::*;
    logic        ref_clk     = 1'b0;
    logic        rst_b       = 1'b0;
    logic [2:0]  reg_addr    = 3'h0;
    logic [7:0]  reg_wdata   = 8'h00;
    logic        reg_wr      = 1'b0;
    logic        reg_rd      = 1'b0;
    logic [4:0]  ev          = 5'h00;
    logic        sleep_exec  = 1'b0;
    logic        return_from_irq_instr_exec = 1'b0;
    logic [3:0]  ctx_we      = 4'h0;
    logic [7:0]  ctx_wdata   = 8'h00;
    logic [7:0]  reg_rdata;
    logic        instr_retire;
    logic        flush, push_pc, pop_pc, load_vector;
    logic [10:0] vector_addr;
    logic        in_isr, core_asleep, wake_reset_req;
    logic [31:0] ctx_active;
    int          failures = 0;
    int          n_tests  = 0;
    int          n_ret    = 0;
    ////////////////////////////////////////////////////////////////////////////////
    irq_ctrl_context_switch u_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_done(ev[0]),
        .timer_ovf(ev[1]), .cmp1_out(ev[2]), .cmp2_out(ev[3]), .pin_change(ev[4]),
        .sleep_exec(sleep_exec), .return_from_irq_instr_exec(return_from_irq_instr_exec), .instr_retire(instr_retire),
        .ctx_we_w(ctx_we[0]), .ctx_we_status(ctx_we[1]), .ctx_we_ptr(ctx_we[2]),
        .ctx_we_bank(ctx_we[3]), .ctx_wdata(ctx_wdata), .flush(flush), .push_pc(push_pc),
        .pop_pc(pop_pc), .load_vector(load_vector), .vector_addr(vector_addr),
        .in_isr(in_isr), .core_asleep(core_asleep), .wake_reset_req(wake_reset_req),
        .ctx_active(ctx_active));
    core_model u_core (.ref_clk(ref_clk), .rst_b(rst_b), .core_asleep(core_asleep),
        .instr_retire(instr_retire));
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (instr_retire === 1'b1) n_ret <= n_ret + 1;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 check("reg_rdata", reg_rdata, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge ref_clk);
        ev[i] <= 1'b1;
        repeat (6) @(posedge ref_clk);
        ev[i] <= 1'b0;
        repeat (6) @(posedge ref_clk);
    endtask
    // k: 0 sleep, 1 return
    task automatic strobe(input int k);
        @(posedge ref_clk);
        if (k == 0) sleep_exec <= 1'b1;
        else return_from_irq_instr_exec <= 1'b1;
        @(posedge ref_clk);
        sleep_exec  <= 1'b0;
        return_from_irq_instr_exec <= 1'b0;
    endtask
    // k: 0 vector, 1 pop, 2 wake reset; samples the current cycle first
    task automatic wait_for(input int k, input int lim);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < lim && !hit; n++) begin
            #1 hit = (k == 0) ? (load_vector === 1'b1) :
                     (k == 1) ? (pop_pc === 1'b1) : (wake_reset_req === 1'b1);
            if (!hit) @(posedge ref_clk);
        end
        if (!hit) begin
            failures++;
            $display("MISMATCH wait_for %0d expected hit seen none", k);
            finish_test();
        end
    endtask
    task automatic no_take(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge ref_clk);
            #1 seen = seen | (load_vector !== 1'b0);
        end
        check("load_vector", {7'h0, seen}, 8'h00);
    endtask
    task automatic ctxw(input logic [7:0] d);
        @(posedge ref_clk);
        ctx_wdata <= d;
        ctx_we    <= 4'hf;
        @(posedge ref_clk);
        ctx_we    <= 4'h0;
        @(posedge ref_clk);
        #1;
        for (int j = 0; j < 4; j++) check("ctx_active", ctx_active[8*j +: 8], d);
    endtask
    task automatic rise_adc();
        @(posedge ref_clk);
        ev[0] <= 1'b1;
    endtask
    task automatic fall_adc();
        @(posedge ref_clk);
        ev[0] <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(ADDR_FLAG, FLAG_RESET);
        rd(ADDR_WAKE_CFG, WAKE_CFG_RESET);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
        wr(ADDR_ENABLE, 8'hff);
        rd(ADDR_ENABLE, 8'hf1);
        wr(ADDR_ENABLE, 8'h00);
        pulse(0);
        pulse(1);
        rd(ADDR_FLAG, 8'ha0);
        rd(ADDR_FLAG, 8'ha0);
        wr(ADDR_FLAG, 8'h00);
        $display("test reset_and_flags done");
        // one gate opened per pass, last pass keeps all three shut
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_WAKE_CFG, 8'h07 & ~(8'h01 << i));
            pulse(2);
            pulse(3);
            pulse(4);
            rd(ADDR_FLAG, (i == 3) ? 8'h00 : (i == 2) ? 8'h10 : 8'h40);
            wr(ADDR_FLAG, 8'h00);
        end
        $display("test wake_gates done");
        ctxw(8'h11);
        wr(ADDR_SH_STATUS, 8'h3c);
        pulse(1);
        pulse(0);
        wr(ADDR_ENABLE, 8'h20);
        no_take(6);
        wr(ADDR_FLAG, 8'ha1);
        wait_for(0, 20);
        rd(ADDR_FLAG, 8'ha0);
        check("ctx_active status", ctx_active[15:8], 8'h3c);
        ctxw(8'h5a);
        rd(ADDR_SH_WORKING, 8'h11);
        wr(ADDR_SH_BANK, 8'h66);
        wr(ADDR_FLAG, 8'h80);
        strobe(1);
        wait_for(1, 4);
        rd(ADDR_FLAG, 8'h81);
        check("ctx_active w", ctx_active[7:0], 8'h11);
        check("ctx_active bank", ctx_active[31:24], 8'h66);
        rd(ADDR_SH_WORKING, 8'h5a);
        no_take(6);
        $display("test irq_take done");
        wr(ADDR_FLAG, 8'h01);
        wr(ADDR_ENABLE, 8'h80);
        strobe(0);
        rise_adc();
        wait_for(0, 30);
        check("retired before vector", n_ret[7:0], 8'h01);
        fall_adc();
        wr(ADDR_FLAG, 8'h00);
        strobe(1);
        wait_for(1, 4);
        wr(ADDR_FLAG, 8'h00);
        strobe(0);
        rise_adc();
        no_take(12);
        check("core_asleep", {7'h0, core_asleep}, 8'h00);
        check("retired inline", n_ret[7:0], 8'h02);
        fall_adc();
        wr(ADDR_FLAG, 8'h00);
        wr(ADDR_ENABLE, 8'h81);
        strobe(0);
        rise_adc();
        wait_for(2, 30);
        $display("test sleep_wake done");
        @(posedge ref_clk);
        rst_b <= 1'b0;
        ev[0] <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(ADDR_FLAG, FLAG_RESET);
        rd(ADDR_ENABLE, ENABLE_RESET);
        $display("test second_reset done");
        finish_test();
    end
endmodule

bind irq_ctrl_context_switch irq_ctrl_checker u_chk (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_exec(sleep_exec), .return_from_irq_instr_exec(return_from_irq_instr_exec), .flush(flush), .push_pc(push_pc),
    .pop_pc(pop_pc), .load_vector(load_vector), .vector_addr(vector_addr), .in_isr(in_isr),
    .core_asleep(core_asleep), .wake_reset_req(wake_reset_req));
